//--- rtl/flash_host.sv
// wishbone-controlled host that sequences commands into a parallel nor flash
`timescale 1ns/1ns
module flash_host
  import flash_host_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] dq_i,
  input wire logic ready_busy_i,
  output flash_out_t flash_o
);
  typedef enum {S_IDLE, S_WSET, S_WLOW, S_WHIGH, S_RLOW, S_RHIGH, S_RST} state_t;
  state_t st_reg;
  op_t op_reg;
  logic [7:0] cnt_reg;
  logic [2:0] step_reg, len_reg;
  logic poll_reg, first_reg, prev_reg;
  logic id_reg, byp_reg, sn_reg;
  logic fail_reg, refused_reg, aborted_reg;
  logic ack_reg, byte_reg;
  logic [31:0] dat_reg;
  logic [19:0] addr_reg;
  logic [15:0] wdata_reg, rdata_reg;
  flash_out_t pins_reg;
  logic acc, cmd_wr, hw_req, legal, start, refuse, fail_ev, abort_ev, stat_wr;
  op_t cmd_op;
  logic [31:0] mask;
  logic [35:0] cur;
  // ----------------------------------------
  // sequence tables
  // ----------------------------------------
  function automatic logic [2:0] seq_len(op_t op, logic byp);
    case (op)
      OP_RESET: seq_len = 3'd1;
      OP_PROGRAM: seq_len = byp ? 3'd2 : 3'd4;
      OP_BYP_EXIT: seq_len = 3'd2;
      OP_ERASE: seq_len = 3'd6;
      OP_SN_EXIT: seq_len = 3'd4;
      OP_ID_ENTER, OP_BYP_ENTER, OP_SN_ENTER: seq_len = 3'd3;
      default: seq_len = 3'd0;
    endcase
  endfunction
  function automatic logic [35:0] seq_word(op_t op, logic [2:0] step, logic byp, logic bm,
    logic [19:0] a, logic [15:0] d);
    logic [19:0] u1, u2;
    logic [7:0] third;
    u1 = {8'h00, bm ? UA_BYTE1 : UA_WORD1};
    u2 = {8'h00, bm ? UA_BYTE2 : UA_WORD2};
    case (op)
      OP_ID_ENTER: third = CD_ID;
      OP_PROGRAM: third = CD_PROG;
      OP_BYP_ENTER: third = CD_BYPASS;
      OP_ERASE: third = CD_ERASE_SETUP;
      OP_SN_ENTER: third = CD_SN_ENTER;
      default: third = CD_EXIT1;
    endcase
    if (op == OP_RESET)
      seq_word = {20'h00000, 8'h00, CD_RESET};
    else if (op == OP_BYP_EXIT)
      seq_word = {20'h00000, 8'h00, step == 3'd0 ? CD_EXIT1 : CD_EXIT2};
    else if (op == OP_PROGRAM && byp)
      seq_word = step == 3'd0 ? {20'h00000, 8'h00, CD_PROG} : {a, d};
    else
    begin
      case (step)
        3'd0: seq_word = {u1, 8'h00, CD_UNLOCK1};
        3'd1: seq_word = {u2, 8'h00, CD_UNLOCK2};
        3'd2: seq_word = {u1, 8'h00, third};
        3'd3: seq_word = op == OP_PROGRAM ? {a, d} :
          op == OP_ERASE ? {u1, 8'h00, CD_UNLOCK1} : {20'h00000, 8'h00, CD_EXIT2};
        3'd4: seq_word = {u2, 8'h00, CD_UNLOCK2};
        default: seq_word = {u1, 8'h00, CD_ERASE_ALL};
      endcase
    end
  endfunction
  // ----------------------------------------
  // command decode
  // ----------------------------------------
  always_comb
  begin
    acc = wb_cyc_i && wb_stb_i && !ack_reg;
    cmd_wr = acc && wb_we_i && wb_adr_i == OFF_CMD && wb_sel_i[0];
    cmd_op = op_t'(wb_dat_i[3:0]);
    hw_req = cmd_wr && cmd_op == OP_HWRESET;
    legal = wb_dat_i[3:0] <= 4'(OP_HWRESET);
    if (byp_reg)
      legal = legal && (cmd_op == OP_PROGRAM || cmd_op == OP_BYP_EXIT);
    else if (id_reg)
      legal = legal && (cmd_op == OP_READ || cmd_op == OP_RESET);
    else
      legal = legal && cmd_op != OP_BYP_EXIT;
    if (sn_reg && cmd_op == OP_BYP_ENTER)
      legal = 1'b0;
    start = cmd_wr && !hw_req && st_reg == S_IDLE && legal;
    refuse = cmd_wr && !hw_req && !(st_reg == S_IDLE && legal);
    fail_ev = st_reg == S_RHIGH && poll_reg && !first_reg &&
      rdata_reg[POLL_TOGGLE] != prev_reg && rdata_reg[POLL_LIMIT];
    abort_ev = hw_req && st_reg != S_IDLE && (op_reg == OP_PROGRAM || op_reg == OP_ERASE);
    stat_wr = acc && wb_we_i && wb_adr_i == OFF_STATUS && wb_sel_i[0];
    mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    cur = seq_word(op_reg, step_reg, byp_reg, byte_reg, addr_reg, wdata_reg);
  end
  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
      addr_reg <= 20'h00000;
      wdata_reg <= 16'h0000;
      byte_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= acc;
      if (acc && wb_we_i && wb_adr_i == OFF_ADDR)
        addr_reg <= (addr_reg & ~mask[19:0]) | (wb_dat_i[19:0] & mask[19:0]);
      if (acc && wb_we_i && wb_adr_i == OFF_WDATA)
        wdata_reg <= (wdata_reg & ~mask[15:0]) | (wb_dat_i[15:0] & mask[15:0]);
      if (acc && wb_we_i && wb_adr_i == OFF_CTRL && wb_sel_i[0])
        byte_reg <= wb_dat_i[0];
      if (acc)
      begin
        case (wb_adr_i)
          OFF_ADDR: dat_reg <= {12'h000, addr_reg};
          OFF_WDATA: dat_reg <= {16'h0000, wdata_reg};
          OFF_STATUS: dat_reg <= {25'h0000000, aborted_reg, refused_reg, fail_reg, sn_reg,
            byp_reg, id_reg, st_reg != S_IDLE};
          OFF_RDATA: dat_reg <= {16'h0000, rdata_reg};
          OFF_CTRL: dat_reg <= {31'h00000000, byte_reg};
          default: dat_reg <= 32'h00000000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign flash_o = pins_reg;
  // ----------------------------------------
  // sticky flags, write one to clear, set wins
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      fail_reg <= 1'b0;
      refused_reg <= 1'b0;
      aborted_reg <= 1'b0;
    end
    else
    begin
      fail_reg <= fail_ev || (fail_reg && !(stat_wr && wb_dat_i[ST_FAIL]));
      refused_reg <= refuse || (refused_reg && !(stat_wr && wb_dat_i[ST_REFUSED]));
      aborted_reg <= abort_ev || (aborted_reg && !(stat_wr && wb_dat_i[ST_ABORTED]));
    end
  end
  // ----------------------------------------
  // bus cycle sequencer and flash pins
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_reg <= S_IDLE;
      op_reg <= OP_READ;
      cnt_reg <= 8'h00;
      step_reg <= 3'd0;
      len_reg <= 3'd0;
      poll_reg <= 1'b0;
      first_reg <= 1'b0;
      prev_reg <= 1'b0;
      id_reg <= 1'b0;
      byp_reg <= 1'b0;
      sn_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      pins_reg <= '{addr: 20'h00000, dout: 16'h0000, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1,
        oe_n: 1'b1, rst_n: 1'b1, byte_n: 1'b1};
    end
    else
    begin
      pins_reg.byte_n <= !byte_reg;
      if (hw_req)
      begin
        st_reg <= S_RST;
        cnt_reg <= 8'(RP_CYC - 1);
        pins_reg.rst_n <= 1'b0;
        pins_reg.ce_n <= 1'b1;
        pins_reg.we_n <= 1'b1;
        pins_reg.oe_n <= 1'b1;
        pins_reg.dq_oe <= 1'b0;
        poll_reg <= 1'b0;
        id_reg <= 1'b0;
        byp_reg <= 1'b0;
        sn_reg <= 1'b0;
      end
      else
      begin
        case (st_reg)
          S_IDLE:
            if (start)
            begin
              op_reg <= cmd_op;
              step_reg <= 3'd0;
              len_reg <= seq_len(cmd_op, byp_reg);
              poll_reg <= 1'b0;
              pins_reg.addr <= addr_reg;
              st_reg <= cmd_op == OP_READ ? S_RLOW : S_WSET;
              cnt_reg <= 8'(RD_CYC - 1);
            end
          S_WSET:
          begin
            pins_reg.addr <= cur[35:16];
            pins_reg.dout <= cur[15:0];
            pins_reg.dq_oe <= 1'b1;
            st_reg <= S_WLOW;
            cnt_reg <= 8'(WP_CYC - 1);
          end
          S_WLOW:
          begin
            pins_reg.ce_n <= 1'b0;
            pins_reg.we_n <= 1'b0;
            if (!pins_reg.we_n)
            begin
              if (cnt_reg == 8'h00)
              begin
                pins_reg.ce_n <= 1'b1;
                pins_reg.we_n <= 1'b1;
                st_reg <= S_WHIGH;
              end
              else
                cnt_reg <= cnt_reg - 8'h01;
            end
          end
          S_WHIGH:
          begin
            pins_reg.dq_oe <= 1'b0;
            step_reg <= step_reg + 3'd1;
            cnt_reg <= 8'(RD_CYC - 1);
            if (step_reg + 3'd1 != len_reg)
              st_reg <= S_WSET;
            else if (op_reg == OP_PROGRAM || op_reg == OP_ERASE)
            begin
              poll_reg <= 1'b1;
              first_reg <= 1'b1;
              st_reg <= S_RLOW;
            end
            else
            begin
              st_reg <= S_IDLE;
              case (op_reg)
                OP_ID_ENTER: id_reg <= 1'b1;
                OP_RESET: id_reg <= 1'b0;
                OP_BYP_ENTER: byp_reg <= 1'b1;
                OP_BYP_EXIT: byp_reg <= 1'b0;
                OP_SN_ENTER: sn_reg <= 1'b1;
                OP_SN_EXIT: sn_reg <= 1'b0;
                default: ;
              endcase
            end
          end
          S_RLOW:
          begin
            pins_reg.ce_n <= 1'b0;
            pins_reg.oe_n <= 1'b0;
            if (cnt_reg == 8'h00)
            begin
              rdata_reg <= dq_i;
              pins_reg.ce_n <= 1'b1;
              pins_reg.oe_n <= 1'b1;
              st_reg <= S_RHIGH;
            end
            else
              cnt_reg <= cnt_reg - 8'h01;
          end
          S_RHIGH:
          begin
            cnt_reg <= 8'(RD_CYC - 1);
            prev_reg <= rdata_reg[POLL_TOGGLE];
            first_reg <= 1'b0;
            if (!poll_reg || (!first_reg && (rdata_reg[POLL_TOGGLE] == prev_reg ||
              rdata_reg[POLL_LIMIT])))
            begin
              poll_reg <= 1'b0;
              st_reg <= S_IDLE;
            end
            else
              st_reg <= S_RLOW;
          end
          S_RST:
            if (cnt_reg == 8'h00)
            begin
              pins_reg.rst_n <= 1'b1;
              st_reg <= S_IDLE;
            end
            else
              cnt_reg <= cnt_reg - 8'h01;
          default: st_reg <= S_IDLE;
        endcase
      end
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  strobe_drive_a: assert property (!flash_o.we_n |-> !flash_o.ce_n && flash_o.dq_oe && flash_o.oe_n)
    else $error("write strobe without driven data");
  strobe_stable_a: assert property (!flash_o.we_n && !$past(flash_o.we_n) |->
    $stable(flash_o.addr) && $stable(flash_o.dout))
    else $error("address or data moved under strobe");
  poll_quiet_a: assert property (poll_reg |-> flash_o.we_n)
    else $error("write during device operation");
  serial_bypass_a: assert property (!(sn_reg && byp_reg))
    else $error("bypass entered with serial region mapped");
  id_exit_a: assert property ($fell(id_reg) |-> $past(op_reg) == OP_RESET || !flash_o.rst_n)
    else $error("id mode left without reset");
  bypass_len_a: assert property (start && cmd_op == OP_PROGRAM && byp_reg |=> len_reg == 3'd2)
    else $error("bypass program length wrong");
  program_len_a: assert property (start && cmd_op == OP_PROGRAM && !byp_reg |=> len_reg == 3'd4)
    else $error("program length wrong");
  erase_len_a: assert property (start && cmd_op == OP_ERASE |=> len_reg == 3'd6)
    else $error("erase length wrong");
  hw_reset_a: assert property (hw_req |=> !flash_o.rst_n && st_reg == S_RST ##1 !flash_o.rst_n)
    else $error("hardware reset not driven");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over two cycles");
endmodule

//--- rtl/flash_host_pkg.sv
// constants and types for the flash command host
package flash_host_pkg;
  // ----------------------------------------
  // register map and status fields
  // ----------------------------------------
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_RDATA = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam int ST_BUSY = 0;
  localparam int ST_ID = 1;
  localparam int ST_BYP = 2;
  localparam int ST_SN = 3;
  localparam int ST_FAIL = 4;
  localparam int ST_REFUSED = 5;
  localparam int ST_ABORTED = 6;
  localparam int POLL_TOGGLE = 6;
  localparam int POLL_LIMIT = 5;
  // ----------------------------------------
  // flash command codes and unlock addresses
  // ----------------------------------------
  localparam logic [7:0] CD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CD_ID = 8'h90;
  localparam logic [7:0] CD_PROG = 8'ha0;
  localparam logic [7:0] CD_BYPASS = 8'h20;
  localparam logic [7:0] CD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CD_ERASE_ALL = 8'h10;
  localparam logic [7:0] CD_RESET = 8'hf0;
  localparam logic [7:0] CD_SN_ENTER = 8'h88;
  localparam logic [7:0] CD_EXIT1 = 8'h90;
  localparam logic [7:0] CD_EXIT2 = 8'h00;
  localparam logic [11:0] UA_WORD1 = 12'h555;
  localparam logic [11:0] UA_WORD2 = 12'h2aa;
  localparam logic [11:0] UA_BYTE1 = 12'haaa;
  localparam logic [11:0] UA_BYTE2 = 12'h555;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 4;
  localparam int T_WP_NS = 40;
  localparam int T_RD_NS = 90;
  localparam int T_RP_NS = 500;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC = (T_RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {OP_READ, OP_ID_ENTER, OP_RESET, OP_PROGRAM, OP_BYP_ENTER,
    OP_BYP_EXIT, OP_ERASE, OP_SN_ENTER, OP_SN_EXIT, OP_HWRESET} op_t;
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] dout;
    logic dq_oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic rst_n;
    logic byte_n;
  } flash_out_t;
endpackage

//--- verification/flash_model.sv
// behavioural nor flash device at the host's pins
`timescale 1ns/1ns
module flash_model
  import flash_host_pkg::*;
#(
  parameter int PROG_CYC = 300,
  parameter int ERASE_CYC = 3000,
  parameter logic [15:0] MAKER = 16'h005a, // arbitrary
  parameter logic [15:0] PART = 16'h00c3, // arbitrary
  parameter logic [7:0] PROT_SEC = 8'h03
)
(
  input wire logic clock_i,
  input wire flash_out_t flash_i,
  output logic [15:0] dq_o,
  output wire logic ready_busy_o
);
  // --------
  // state
  // --------
  logic [15:0] mem [logic [19:0]];
  logic [19:0] lat = '0;
  logic [15:0] rd;
  logic [7:0] off;
  int step = 0;
  int cnt = 0;
  logic busy = 0, fail = 0, tgl = 0, pbit = 0, id = 0, byp = 0, sn = 0, armed = 0, ers = 0;
  wire [11:0] u1 = flash_i.byte_n ? UA_WORD1 : UA_BYTE1;
  wire [11:0] u2 = flash_i.byte_n ? UA_WORD2 : UA_BYTE2;
  initial dq_o = 16'h0000;
  assign ready_busy_o = !busy;
  function automatic logic [15:0] get(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  task automatic prog();
    fail = |(flash_i.dout & ~get(lat));
    pbit = ~flash_i.dout[7];
    mem[lat] = get(lat) & flash_i.dout;
    busy = 1;
    cnt = PROG_CYC;
  endtask
  // --------
  // command decoder
  // --------
  task automatic wr(input logic [7:0] d);
    int nx;
    logic [11:0] a;
    nx = 0;
    a = lat[11:0];
    if (busy && !(fail && d == CD_RESET)) return;
    if (busy)
    begin
      busy = 0;
      fail = 0;
    end
    else if (id) id = (d != CD_RESET);
    else if (byp)
    begin
      if (step == 1) prog();
      if (step == 2 && d == CD_EXIT2) byp = 0;
      if (step == 0 && d == CD_PROG) nx = 1;
      if (step == 0 && d == CD_EXIT1) nx = 2;
    end
    else if (d != CD_RESET)
      case (step)
        0: nx = (a == u1 && d == CD_UNLOCK1) ? 1 : 0;
        1: nx = (a == u2 && d == CD_UNLOCK2) ? 2 : 0;
        2: if (a == u1)
          case (d)
            CD_ID: if (sn) nx = 7; else id = 1;
            CD_PROG: nx = 3;
            CD_BYPASS: byp = !sn;
            CD_ERASE_SETUP: nx = 4;
            CD_SN_ENTER: sn = 1;
            default: nx = 0;
          endcase
        3: prog();
        4: nx = (a == u1 && d == CD_UNLOCK1) ? 5 : 0;
        5: nx = (a == u2 && d == CD_UNLOCK2) ? 6 : 0;
        6: if (a == u1 && d == CD_ERASE_ALL)
        begin
          ers = 1;
          pbit = 0;
          busy = 1;
          cnt = ERASE_CYC;
        end
        7: if (d == CD_EXIT2) sn = 0;
        default: nx = 0;
      endcase
    step = nx;
  endtask
  always @(negedge flash_i.we_n or negedge flash_i.ce_n)
    if (!flash_i.we_n && !flash_i.ce_n && flash_i.oe_n)
    begin
      lat = flash_i.addr;
      armed = 1;
    end
  always @(posedge flash_i.we_n or posedge flash_i.ce_n)
    if (armed)
    begin
      armed = 0;
      wr(flash_i.dout[7:0]);
    end
  // --------
  // timing and read data
  // --------
  always @(posedge clock_i or negedge flash_i.rst_n)
    if (!flash_i.rst_n)
    begin
      {busy, fail, id, byp, sn, ers} = '0;
      step = 0;
    end
    else
    begin
      if (busy && !fail) cnt = cnt - 1;
      if (busy && !fail && cnt == 0)
      begin
        busy = 0;
        if (ers) mem.delete();
        ers = 0;
      end
      off = flash_i.byte_n ? 8'h02 : 8'h04;
      if (busy) rd = {8'h00, pbit, tgl, fail, 2'b00, tgl, 2'b00};
      else if (id && flash_i.addr[7:0] == 8'h00) rd = MAKER;
      else if (id && flash_i.addr[7:0] == 8'h01) rd = PART;
      else if (id && flash_i.addr[7:0] == off) rd = {15'h0, flash_i.addr[19:12] == PROT_SEC};
      else if (id) rd = 16'h0000;
      else if (sn) rd = {12'h5e0, flash_i.addr[3:0]};
      else rd = get(flash_i.addr);
      dq_o <= (!flash_i.ce_n && !flash_i.oe_n) ? rd : ~dq_o;
    end
  always @(negedge flash_i.oe_n)
    if (busy) tgl = ~tgl;
endmodule

//--- verification/tb_top.sv
// self-checking bench for the wishbone flash command host
`timescale 1ns/1ns
module tb_top;
  import flash_host_pkg::*;
  localparam logic [15:0] MK = 16'h005a; // arbitrary
  localparam logic [15:0] PT = 16'h00c3; // arbitrary
  logic clock_i = 0, reset_n_i = 0, cyc = 0, stb = 0, we = 0, ack, rb;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q, st;
  logic [15:0] dq_m, dq_w, pd [8];
  logic [19:0] pa [8];
  flash_out_t fo;
  int n_fail = 0, n_checks = 0, seed = 97704;
  always #2 clock_i = ~clock_i;
  assign dq_w = fo.dq_oe ? fo.dout : dq_m;
  flash_host u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .dq_i(dq_w),
    .ready_busy_i(rb), .flash_o(fo));
  flash_model #(.MAKER(MK), .PART(PT), .PROT_SEC(8'h03)) u_mem (.clock_i(clock_i), .flash_i(fo),
    .dq_o(dq_m), .ready_busy_o(rb));
  // --------
  // tasks
  // --------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] prog_exp(input logic [15:0] old, input logic [15:0] d);
    return {16'h0, old & d};
  endfunction
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
    begin
      n_fail++;
      tally_and_finish();
    end
    q = rdat;
    cyc <= 0;
    stb <= 0;
    @(posedge clock_i);
  endtask
  task automatic op(input op_t o, input logic refused);
    int n;
    n = 0;
    wb(1, OFF_CMD, {28'h0, o});
    do
    begin
      wb(0, OFF_STATUS, 0);
      n++;
    end
    while (q[ST_BUSY] !== 1'b0 && n < 3000);
    if (q[ST_BUSY] !== 1'b0)
    begin
      n_fail++;
      tally_and_finish();
    end
    st = q;
    chk(st[ST_REFUSED], refused);
    wb(1, OFF_STATUS, 32'h70);
  endtask
  task automatic pg(input logic [19:0] a, input logic [15:0] d);
    wb(1, OFF_ADDR, {12'h0, a});
    wb(1, OFF_WDATA, {16'h0, d});
    op(OP_PROGRAM, 0);
  endtask
  task automatic rdf(input logic [19:0] a, input logic [15:0] e);
    wb(1, OFF_ADDR, {12'h0, a});
    op(OP_READ, 0);
    wb(0, OFF_RDATA, 0);
    chk(q, {16'h0, e});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // --------
  // scenarios
  // --------
  initial
  begin
    repeat (90000) @(posedge clock_i);
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1;
    @(posedge clock_i);
    chk({27'h0, fo.rst_n, fo.ce_n, fo.we_n, fo.oe_n, fo.dq_oe}, 32'h1e);
    wb(0, 8'h20, 0);
    chk(q, 0);
    for (int i = 0; i < 8; i++)
    begin
      pa[i] = {i[3:0], 16'($random(seed))};
      pd[i] = 16'($random(seed)) & 16'h7fff;
    end
    pa[5] = 20'h5ffff;
    for (int i = 0; i < 6; i++) pg(pa[i], pd[i]);
    for (int i = 5; i >= 0; i--) rdf(pa[i], pd[i]);
    wb(1, OFF_ADDR, {12'h0, pa[0]});
    wb(1, OFF_WDATA, 32'hffff);
    wb(1, OFF_CMD, {28'h0, OP_PROGRAM});
    op(OP_READ, 1);
    chk(st[ST_FAIL], 1);
    op(OP_RESET, 0);
    rdf(pa[0], prog_exp(pd[0], 16'hffff));
    for (int bm = 0; bm < 2; bm++)
    begin
      wb(1, OFF_CTRL, bm);
      chk(fo.byte_n, bm == 0);
      op(OP_ID_ENTER, 0);
      chk(st[ST_ID], 1);
      rdf(20'h00300, MK);
      rdf(20'h00301, PT);
      rdf({8'h03, 4'h0, bm ? 8'h04 : 8'h02}, 1);
      rdf({8'h05, 4'h0, bm ? 8'h04 : 8'h02}, 0);
      op(OP_PROGRAM, 1);
      rdf(20'h00300, MK);
      op(OP_RESET, 0);
      chk(st[ST_ID], 0);
    end
    wb(1, OFF_CTRL, 0);
    op(OP_SN_ENTER, 0);
    chk(st[ST_SN], 1);
    rdf(20'h00007, 16'h5e07);
    op(OP_BYP_ENTER, 1);
    op(OP_SN_EXIT, 0);
    chk(st[ST_SN], 0);
    rdf(pa[1], pd[1]);
    op(OP_BYP_ENTER, 0);
    chk(st[ST_BYP], 1);
    pg(pa[6], pd[6]);
    pg(pa[7], pd[7]);
    op(OP_ERASE, 1);
    op(OP_BYP_EXIT, 0);
    chk(st[ST_BYP], 0);
    op(OP_BYP_EXIT, 1);
    rdf(pa[7], pd[7]);
    op(OP_ERASE, 0);
    rdf(pa[3], 16'hffff);
    rdf(pa[6], 16'hffff);
    pg(pa[2], pd[2]);
    wb(1, OFF_CMD, {28'h0, OP_ERASE});
    for (int n = 0; n < 300 && rb !== 1'b0; n++) @(posedge clock_i);
    chk(rb, 0);
    op(OP_HWRESET, 0);
    chk(st[ST_ABORTED], 1);
    chk(rb, 1);
    rdf(pa[2], pd[2]);
    op(OP_ERASE, 0);
    rdf(pa[2], 16'hffff);
    tally_and_finish();
  end
endmodule
